/* hdl/homing_consts.vh */
// constants of the homing sequencer: register offsets, fields, reset values, timing
`ifndef HOMING_CONSTS_VH
`define HOMING_CONSTS_VH

// register byte offsets
`define HOME_REG_CTRL 8'h00
`define HOME_REG_VELOCITY 8'h04
`define HOME_REG_ACCEL 8'h08
`define HOME_REG_DECEL 8'h0C
`define HOME_REG_LIMIT_DIST 8'h10
`define HOME_REG_END_POS 8'h14
`define HOME_REG_FILTER 8'h18
`define HOME_REG_FLAGS 8'h1C
`define HOME_REG_REF_POS 8'h20
`define HOME_REG_IRQ_STATUS 8'h24
`define HOME_REG_IRQ_CLEAR 8'h28
`define HOME_REG_IRQ_ENABLE 8'h2C

// control field positions
`define HOME_CTRL_REFSEL_LSB 0
`define HOME_CTRL_REFSEL_MSB 1
`define HOME_CTRL_BACKOFF 2
`define HOME_CTRL_FILTER_EN 3
`define HOME_CTRL_LIMIT_EN 4

// reference source encodings
`define HOME_REF_SENSOR 2'h0
`define HOME_REF_MARKER 2'h1
`define HOME_REF_SENSOR_MARKER 2'h2

// flag field positions (flags register)
`define HOME_FLAG_ACCEL 0
`define HOME_FLAG_AT_VEL 1
`define HOME_FLAG_DECEL 2
`define HOME_FLAG_RUNNING 3
`define HOME_FLAG_DONE 4
`define HOME_FLAG_ANY_DONE 5
`define HOME_FLAG_LIMIT 6
`define HOME_FLAG_POS_VALID 7

// interrupt event positions
`define HOME_IRQ_DONE 0
`define HOME_IRQ_LIMIT 1
`define HOME_IRQ_ABORT 2
`define HOME_IRQ_REF 3
`define HOME_IRQ_WIDTH 4

// reset values
`define HOME_RST_CTRL 32'h0000_0000
`define HOME_RST_VELOCITY 32'h0000_0000
`define HOME_RST_ACCEL 32'h0000_0000
`define HOME_RST_DECEL 32'h0000_0000
`define HOME_RST_LIMIT_DIST 32'h0000_0000
`define HOME_RST_END_POS 32'h0000_0000
`define HOME_RST_FILTER 32'h0000_0000

// timing: run-on time after the reference, in microseconds, and the clock in MHz
`define HOME_RUNON_US 1600
`define HOME_CLK_MHZ 125
`define HOME_RUNON_CYCLES (`HOME_RUNON_US * `HOME_CLK_MHZ)

`endif

/* hdl/homing_sequence_control.v */
// homing sequencer for one servo axis, with register port and interrupt
//
// Notes on behaviour
// - no reference within limit: stop there, flag
// - at completion load feedback and command position
// - position valid after good home, cleared otherwise
// - any-home-done set on finish, not after stop
// - accelerating flag while ramping up, backoff too
// - at-speed flag until decel, never in backoff
// - done flag at ramp end, held until retrigger
// - running flag from trigger until motion ends
// - decelerating flag while ramping down, backoff too
// - limit flag held until next trigger
// - start only on rising trigger edge
// - ignore trigger while busy, stopped or limited
// - reference edge latches the home position
// - sensor active at start: backoff or skip
// - filter delays acceptance, keeps rising-edge position
// - reference: sensor, marker, or sensor then marker
// - backoff reversed at home speed until release
// - offset equals braking plus run-on for a fixed time
`timescale 1ns/100ps
`default_nettype none
`include "homing_consts.vh"

module homing_sequence_control #(
	parameter [31:0] RUNON_CYCLES = `HOME_RUNON_CYCLES
) (
	// clock, reset, enable
	input wire clk_sys,
	input wire resetn,
	input wire clkEn,
	// register port
	input wire [7:0] regAddr,
	input wire [31:0] regWrData,
	input wire regWrStb,
	input wire regRdStb,
	output reg [31:0] regRdData,
	// pins from outside the clock domain
	input wire homeTrigger,
	input wire reference_sensor_input,
	input wire encoderMarker,
	input wire stopInput,
	input wire travelLimitPos,
	input wire travelLimitNeg,
	input wire encoderFault,
	input wire mainPowerLost,
	input wire backup_logic_supply,
	// other motion on the same clock
	input wire indexBusy,
	input wire jogBusy,
	input wire programBusy,
	input wire [31:0] feedbackPos,
	// profile commands to the motion generator
	output reg [31:0] cmdVelocity,
	output reg posLoad,
	output reg [31:0] posLoadValue,
	// status flags
	output reg accelerating_flag,
	output reg at_target_speed_flag,
	output reg decelerating_flag,
	output reg home_running_flag,
	output reg home_done_flag,
	output reg any_home_done_flag,
	output reg limit_reached_flag,
	output reg position_valid_flag,
	output wire irq
);

	localparam [2:0] S_IDLE = 3'd0;
	localparam [2:0] S_BACK_RUN = 3'd1;
	localparam [2:0] S_BACK_STOP = 3'd2;
	localparam [2:0] S_SEARCH = 3'd3;
	localparam [2:0] S_RUNON = 3'd4;
	localparam [2:0] S_FINAL = 3'd5;
	localparam [2:0] S_LIMIT = 3'd6;

	// move cur toward tgt by at most stp
	function [31:0] rampTo;
		input [31:0] cur;
		input [31:0] tgt;
		input [31:0] stp;
		begin
			if (cur < tgt) begin
				rampTo = (tgt - cur > stp) ? cur + stp : tgt;
			end else if (cur > tgt) begin
				rampTo = (cur - tgt > stp) ? cur - stp : tgt;
			end else begin
				rampTo = cur;
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: stage one is read only by stage two

	reg [7:0] syncA_ff;
	reg [7:0] syncB_ff;
	reg trigPrev_ff;
	reg sensPrev_ff;
	reg markPrev_ff;
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			syncA_ff <= 8'h00;
			syncB_ff <= 8'h00;
			trigPrev_ff <= 1'b0;
			sensPrev_ff <= 1'b0;
			markPrev_ff <= 1'b0;
		end else if (clkEn) begin
			syncA_ff <= {mainPowerLost, encoderFault, travelLimitNeg, travelLimitPos,
				stopInput, encoderMarker, reference_sensor_input, homeTrigger};
			syncB_ff <= syncA_ff;
			trigPrev_ff <= syncB_ff[0];
			sensPrev_ff <= syncB_ff[1];
			markPrev_ff <= syncB_ff[2];
		end
	end

	wire trigLvl = syncB_ff[0];
	wire sensLvl = syncB_ff[1];
	wire markLvl = syncB_ff[2];
	wire stopLvl = syncB_ff[3];
	wire limitLvl = syncB_ff[4] | syncB_ff[5];
	wire faultLvl = syncB_ff[6];
	wire powerLostLvl = syncB_ff[7];
	wire trigRise = trigLvl & ~trigPrev_ff;
	wire sensRise = sensLvl & ~sensPrev_ff;
	wire markRise = markLvl & ~markPrev_ff;

	////////////////////////////////////////////////////////////////////////////
	// configuration registers

	reg [31:0] ctrl_ff;
	reg [31:0] velocity_ff;
	reg [31:0] accel_ff;
	reg [31:0] decel_ff;
	reg [31:0] limitDist_ff;
	reg [31:0] endPos_ff;
	reg [31:0] filterCycles_ff;
	reg [`HOME_IRQ_WIDTH-1:0] irqEnable_ff;
	reg [`HOME_IRQ_WIDTH-1:0] irqStatus_ff;
	reg [31:0] refPos_ff;

	wire [1:0] refSel = ctrl_ff[`HOME_CTRL_REFSEL_MSB:`HOME_CTRL_REFSEL_LSB];
	wire backOffMode = ctrl_ff[`HOME_CTRL_BACKOFF];
	wire filterEn = ctrl_ff[`HOME_CTRL_FILTER_EN];
	wire limitEn = ctrl_ff[`HOME_CTRL_LIMIT_EN];
	wire homeDirNeg = velocity_ff[31];
	wire [31:0] homeSpeed = homeDirNeg ? (~velocity_ff + 32'h0000_0001) : velocity_ff;
	wire wrHit = regWrStb & clkEn;

	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ctrl_ff <= `HOME_RST_CTRL;
			velocity_ff <= `HOME_RST_VELOCITY;
			accel_ff <= `HOME_RST_ACCEL;
			decel_ff <= `HOME_RST_DECEL;
			limitDist_ff <= `HOME_RST_LIMIT_DIST;
			endPos_ff <= `HOME_RST_END_POS;
			filterCycles_ff <= `HOME_RST_FILTER;
			irqEnable_ff <= {`HOME_IRQ_WIDTH{1'b0}};
		end else if (wrHit) begin
			case (regAddr)
				`HOME_REG_CTRL: ctrl_ff <= regWrData;
				`HOME_REG_VELOCITY: velocity_ff <= regWrData;
				`HOME_REG_ACCEL: accel_ff <= regWrData;
				`HOME_REG_DECEL: decel_ff <= regWrData;
				`HOME_REG_LIMIT_DIST: limitDist_ff <= regWrData;
				`HOME_REG_END_POS: endPos_ff <= regWrData;
				`HOME_REG_FILTER: filterCycles_ff <= regWrData;
				`HOME_REG_IRQ_ENABLE: irqEnable_ff <= regWrData[`HOME_IRQ_WIDTH-1:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sensor filter and reference capture

	reg [31:0] filterCnt_ff;
	reg filterArmed_ff;
	reg [31:0] pendPos_ff;
	reg markerArmed_ff;
	reg [2:0] state_ff;
	reg [2:0] nxt_state;

	// position is taken at the raw rising edge even when acceptance waits
	wire filterDone = filterArmed_ff & sensLvl & (filterCnt_ff >= filterCycles_ff);
	wire sensAccept = filterEn ? filterDone : sensRise;
	wire [31:0] sensPos = filterEn ? pendPos_ff : feedbackPos;
	wire searching = (state_ff == S_SEARCH);

	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			filterCnt_ff <= 32'h0000_0000;
			filterArmed_ff <= 1'b0;
			pendPos_ff <= 32'h0000_0000;
		end else if (clkEn) begin
			if (sensRise) begin
				pendPos_ff <= feedbackPos;
				filterArmed_ff <= 1'b1;
				filterCnt_ff <= 32'h0000_0001;
			end else if (!sensLvl || filterDone) begin
				filterArmed_ff <= 1'b0;
			end else if (filterArmed_ff) begin
				filterCnt_ff <= filterCnt_ff + 32'h0000_0001;
			end
		end
	end

	reg refFound;
	reg [31:0] refFoundPos;
	always @* begin
		refFound = 1'b0;
		refFoundPos = feedbackPos;
		if (searching) begin
			case (refSel)
				`HOME_REF_SENSOR: begin
					refFound = sensAccept;
					refFoundPos = sensPos;
				end
				`HOME_REF_MARKER: refFound = markRise;
				`HOME_REF_SENSOR_MARKER: refFound = markerArmed_ff & markRise;
				default: refFound = 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// home state machine and velocity profile

	reg [31:0] speed_ff;
	reg runNeg_ff;
	reg [31:0] startPos_ff;
	reg [31:0] runOnCnt_ff;

	wire startOk = trigRise & ~indexBusy & ~jogBusy & ~programBusy & ~stopLvl
		& ~limitLvl & (state_ff == S_IDLE);
	wire [31:0] travelled = runNeg_ff ? (startPos_ff - feedbackPos) : (feedbackPos - startPos_ff);
	wire [31:0] remaining = (travelled < limitDist_ff) ? (limitDist_ff - travelled) : 32'h0000_0000;
	// twice decel times a bound on the stop run: this cycle, the held cycle, then the ramp
	wire [63:0] stopSpan = {32'h0000_0000, speed_ff}
		* ({32'h0000_0000, speed_ff} + 64'h0000_0000_0000_0005 * {32'h0000_0000, decel_ff})
		+ {32'h0000_0000, decel_ff} * {32'h0000_0000, decel_ff};
	wire [63:0] brakeNeed = {32'h0000_0000, decel_ff} * {32'h0000_0000, remaining};
	// brake once one more cycle at speed could overrun, so the stop never passes the limit
	wire limitBrake = limitEn & searching & (stopSpan > {brakeNeed[62:0], 1'b0});
	wire aborting = (state_ff != S_IDLE) & stopLvl;
	wire finishing = (state_ff == S_FINAL || state_ff == S_LIMIT) && speed_ff == 32'h0000_0000;

	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			S_IDLE: begin
				if (startOk) begin
					nxt_state = (sensLvl && backOffMode) ? S_BACK_RUN : S_SEARCH;
				end
			end
			S_BACK_RUN: if (!sensLvl) nxt_state = S_BACK_STOP;
			S_BACK_STOP: if (speed_ff == 32'h0000_0000) nxt_state = S_SEARCH;
			S_SEARCH: begin
				if (refFound) begin
					nxt_state = S_RUNON;
				end else if (limitBrake) begin
					nxt_state = S_LIMIT;
				end
			end
			S_RUNON: if (runOnCnt_ff >= RUNON_CYCLES) nxt_state = S_FINAL;
			S_FINAL: if (speed_ff == 32'h0000_0000) nxt_state = S_IDLE;
			S_LIMIT: if (speed_ff == 32'h0000_0000) nxt_state = S_IDLE;
			default: nxt_state = S_IDLE;
		endcase
		if (aborting) begin
			nxt_state = S_IDLE;
		end
	end

	reg [31:0] nxt_speed;
	always @* begin
		case (state_ff)
			S_BACK_RUN: nxt_speed = rampTo(speed_ff, homeSpeed, accel_ff);
			S_SEARCH: nxt_speed = rampTo(speed_ff, homeSpeed, accel_ff);
			S_RUNON: nxt_speed = rampTo(speed_ff, homeSpeed, accel_ff);
			S_BACK_STOP: nxt_speed = rampTo(speed_ff, 32'h0000_0000, decel_ff);
			S_FINAL: nxt_speed = rampTo(speed_ff, 32'h0000_0000, decel_ff);
			S_LIMIT: nxt_speed = rampTo(speed_ff, 32'h0000_0000, decel_ff);
			default: nxt_speed = 32'h0000_0000;
		endcase
		// a drive stop drops the commanded speed at once
		if (aborting || (state_ff == S_SEARCH && limitBrake)) begin
			nxt_speed = aborting ? 32'h0000_0000 : speed_ff;
		end
	end

	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_ff <= S_IDLE;
			speed_ff <= 32'h0000_0000;
			runNeg_ff <= 1'b0;
			startPos_ff <= 32'h0000_0000;
			runOnCnt_ff <= 32'h0000_0000;
			markerArmed_ff <= 1'b0;
			refPos_ff <= 32'h0000_0000;
			cmdVelocity <= 32'h0000_0000;
			posLoad <= 1'b0;
			posLoadValue <= 32'h0000_0000;
		end else if (clkEn) begin
			state_ff <= nxt_state;
			speed_ff <= nxt_speed;
			cmdVelocity <= runNeg_ff ? (~nxt_speed + 32'h0000_0001) : nxt_speed;
			posLoad <= 1'b0;
			if (startOk) begin
				runNeg_ff <= (sensLvl && backOffMode) ? ~homeDirNeg : homeDirNeg;
				startPos_ff <= feedbackPos;
				markerArmed_ff <= 1'b0;
			end
			if (state_ff == S_BACK_STOP && nxt_state == S_SEARCH) begin
				runNeg_ff <= homeDirNeg;
				startPos_ff <= feedbackPos;
			end
			if (searching && sensAccept) begin
				markerArmed_ff <= 1'b1;
			end
			runOnCnt_ff <= (state_ff == S_RUNON) ? runOnCnt_ff + 32'h0000_0001 : 32'h0000_0000;
			if (refFound) begin
				refPos_ff <= refFoundPos;
			end
			if (finishing && !aborting) begin
				posLoad <= 1'b1;
				posLoadValue <= endPos_ff;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status flags

	wire rampingUp = (state_ff == S_BACK_RUN || state_ff == S_SEARCH || state_ff == S_RUNON)
		&& speed_ff != homeSpeed;
	wire rampingDown = (state_ff == S_BACK_STOP || state_ff == S_FINAL || state_ff == S_LIMIT)
		&& speed_ff != 32'h0000_0000;
	wire clearValid = faultLvl | (powerLostLvl & ~backup_logic_supply);

	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			accelerating_flag <= 1'b0;
			at_target_speed_flag <= 1'b0;
			decelerating_flag <= 1'b0;
			home_running_flag <= 1'b0;
			home_done_flag <= 1'b0;
			any_home_done_flag <= 1'b0;
			limit_reached_flag <= 1'b0;
			position_valid_flag <= 1'b0;
		end else if (clkEn) begin
			accelerating_flag <= rampingUp & ~aborting;
			at_target_speed_flag <= (state_ff == S_SEARCH || state_ff == S_RUNON)
				&& nxt_state != S_FINAL && nxt_state != S_LIMIT
				&& speed_ff == homeSpeed && !aborting;
			decelerating_flag <= rampingDown & ~aborting;
			if (startOk) begin
				home_running_flag <= 1'b1;
				home_done_flag <= 1'b0;
				any_home_done_flag <= 1'b0;
				limit_reached_flag <= 1'b0;
				position_valid_flag <= 1'b0;
			end else begin
				if (aborting) begin
					home_running_flag <= 1'b0;
				end
				if (finishing && !aborting) begin
					home_running_flag <= 1'b0;
					home_done_flag <= 1'b1;
					any_home_done_flag <= 1'b1;
					if (state_ff == S_FINAL) begin
						position_valid_flag <= 1'b1;
					end
				end
				if (state_ff == S_SEARCH && limitBrake && !refFound && !aborting) begin
					limit_reached_flag <= 1'b1;
				end
				if (clearValid) begin
					position_valid_flag <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupts: sticky status, set wins over a clear in the same cycle

	wire [`HOME_IRQ_WIDTH-1:0] irqEvents;
	assign irqEvents[`HOME_IRQ_DONE] = finishing & ~aborting;
	assign irqEvents[`HOME_IRQ_LIMIT] = (state_ff == S_SEARCH) & limitBrake & ~refFound & ~aborting;
	assign irqEvents[`HOME_IRQ_ABORT] = aborting;
	assign irqEvents[`HOME_IRQ_REF] = refFound & ~aborting;
	wire clearHit = wrHit & (regAddr == `HOME_REG_IRQ_CLEAR);
	wire [`HOME_IRQ_WIDTH-1:0] clearMask = clearHit ? regWrData[`HOME_IRQ_WIDTH-1:0]
		: {`HOME_IRQ_WIDTH{1'b0}};

	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irqStatus_ff <= {`HOME_IRQ_WIDTH{1'b0}};
		end else if (clkEn) begin
			irqStatus_ff <= (irqStatus_ff & ~clearMask) | irqEvents;
		end
	end

	assign irq = |(irqStatus_ff & irqEnable_ff);

	////////////////////////////////////////////////////////////////////////////
	// read port: data valid the cycle after the strobe, zero elsewhere

	wire [7:0] flagWord = {position_valid_flag, limit_reached_flag, any_home_done_flag,
		home_done_flag, home_running_flag, decelerating_flag, at_target_speed_flag,
		accelerating_flag};
	reg [31:0] rdMux;
	always @* begin
		case (regAddr)
			`HOME_REG_CTRL: rdMux = ctrl_ff;
			`HOME_REG_VELOCITY: rdMux = velocity_ff;
			`HOME_REG_ACCEL: rdMux = accel_ff;
			`HOME_REG_DECEL: rdMux = decel_ff;
			`HOME_REG_LIMIT_DIST: rdMux = limitDist_ff;
			`HOME_REG_END_POS: rdMux = endPos_ff;
			`HOME_REG_FILTER: rdMux = filterCycles_ff;
			`HOME_REG_FLAGS: rdMux = {24'h00_0000, flagWord};
			`HOME_REG_REF_POS: rdMux = refPos_ff;
			`HOME_REG_IRQ_STATUS: rdMux = {28'h000_0000, irqStatus_ff};
			`HOME_REG_IRQ_ENABLE: rdMux = {28'h000_0000, irqEnable_ff};
			default: rdMux = 32'h0000_0000;
		endcase
	end

	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			regRdData <= 32'h0000_0000;
		end else if (clkEn) begin
			regRdData <= regRdStb ? rdMux : 32'h0000_0000;
		end
	end

endmodule

`default_nettype wire

/* dv/homing_sequence_control_checker.sv */
// port checker for the homing sequencer, bound to the design
`timescale 1ns/100ps
`default_nettype none
`include "homing_consts.vh"
module homing_sequence_control_checker (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic clkEn,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrStb,
	// pins and motion
	input wire logic stopInput,
	input wire logic indexBusy,
	input wire logic jogBusy,
	input wire logic programBusy,
	input wire logic posLoad,
	input wire logic [31:0] posLoadValue,
	// flags
	input wire logic accelerating_flag,
	input wire logic at_target_speed_flag,
	input wire logic decelerating_flag,
	input wire logic home_running_flag,
	input wire logic home_done_flag,
	input wire logic any_home_done_flag,
	input wire logic limit_reached_flag,
	input wire logic position_valid_flag
);
	logic [31:0] endPos_ff;
	// shadow of the end position register, seen only through writes
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			endPos_ff <= 32'h0000_0000;
		end else if (clkEn && regWrStb && regAddr == `HOME_REG_END_POS) begin
			endPos_ff <= regWrData;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	////////////////////////////////////////////////////////////////
	a_load_end_value: assert property (posLoad |-> posLoadValue == endPos_ff)
		else $error("load value differs from end position");
	a_valid_on_load: assert property ($rose(position_valid_flag) |-> posLoad && home_done_flag)
		else $error("position valid rose without a completed home");
	a_any_with_done: assert property ($rose(any_home_done_flag) |-> $rose(home_done_flag))
		else $error("any-done rose alone");
	a_speed_exclusive: assert property (at_target_speed_flag |-> !accelerating_flag && !decelerating_flag)
		else $error("at-speed overlaps a ramp");
	a_done_after_decel: assert property ($rose(home_done_flag) |-> $past(decelerating_flag) && !home_running_flag)
		else $error("done without a finished ramp");
	a_limit_hold: assert property (limit_reached_flag |=> limit_reached_flag || home_running_flag)
		else $error("limit flag dropped without retrigger");
	a_start_clears: assert property ($rose(home_running_flag) |-> !home_done_flag && !any_home_done_flag && !limit_reached_flag && !position_valid_flag)
		else $error("start left old flags set");
	a_busy_blocks: assert property ($rose(home_running_flag) |-> !$past(indexBusy) && !$past(jogBusy) && !$past(programBusy))
		else $error("home started beside other motion");
	a_stop_aborts: assert property (stopInput [*6] |-> !home_running_flag && !$rose(home_done_flag))
		else $error("home survived a stop");
endmodule
bind homing_sequence_control homing_sequence_control_checker chk (.clk_sys, .resetn, .clkEn, .regAddr,
	.regWrData, .regWrStb, .stopInput, .indexBusy, .jogBusy, .programBusy, .posLoad, .posLoadValue,
	.accelerating_flag, .at_target_speed_flag, .decelerating_flag, .home_running_flag,
	.home_done_flag, .any_home_done_flag, .limit_reached_flag, .position_valid_flag);
`default_nettype wire

/* dv/home_far_side.sv */
// far-side model: profile generator, encoder count, home sensor, marker
`timescale 1ns/100ps
`default_nettype none
module home_far_side (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// profile commands
	input wire logic [31:0] cmdVelocity,
	input wire logic posLoad,
	input wire logic [31:0] posLoadValue,
	input wire logic [31:0] sensorAt,
	// encoder and sensor
	output var logic [31:0] feedbackPos,
	output wire logic reference_sensor_input,
	output wire logic encoderMarker
);
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			feedbackPos <= 32'h0000_0000;
		end else if (posLoad) begin
			feedbackPos <= posLoadValue;
		end else begin
			feedbackPos <= feedbackPos + cmdVelocity;
		end
	end
	// marker 8 counts wide so the fastest move still lands in it
	assign reference_sensor_input = $signed(feedbackPos) >= $signed(sensorAt);
	assign encoderMarker = feedbackPos[5:3] == 3'h0;
endmodule
`default_nettype wire

/* dv/tb_homing_sequence_control.sv */
// self-checking bench for the homing sequencer
`timescale 1ns/100ps
`default_nettype none
`include "homing_consts.vh"
module tb_homing_sequence_control;
	localparam logic [31:0] RunOn = 32'h0000_0014;
	localparam logic [31:0] DoneFl = 32'h0000_00B0;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0000_0000;
	logic regWrStb = 1'b0;
	logic regRdStb = 1'b0;
	logic homeTrigger = 1'b0;
	logic [5:0] block = 6'h00;
	logic encoderFault = 1'b0;
	logic mainPowerLost = 1'b0;
	logic backup_logic_supply = 1'b1;
	logic [31:0] sensorAt = 32'h0000_0100;
	logic [31:0] rdVal, endPos;
	logic [2:0] back;
	wire [31:0] regRdData, cmdVelocity, posLoadValue, feedbackPos;
	wire posLoad, sensorIn, marker, irq, acc, atVel, dec, running, done, anyDone, limitHit, posValid;
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;
	int seedDummy, vel, lo, hi;
	homing_sequence_control #(.RUNON_CYCLES(RunOn)) dut (.clk_sys, .resetn, .clkEn(1'b1), .regAddr,
		.regWrData, .regWrStb, .regRdStb, .regRdData, .homeTrigger,
		.reference_sensor_input(sensorIn), .encoderMarker(marker), .stopInput(block[3]),
		.travelLimitPos(block[4]), .travelLimitNeg(block[5]), .encoderFault, .mainPowerLost,
		.backup_logic_supply, .indexBusy(block[0]), .jogBusy(block[1]), .programBusy(block[2]),
		.feedbackPos, .cmdVelocity, .posLoad, .posLoadValue, .accelerating_flag(acc),
		.at_target_speed_flag(atVel), .decelerating_flag(dec), .home_running_flag(running),
		.home_done_flag(done), .any_home_done_flag(anyDone), .limit_reached_flag(limitHit),
		.position_valid_flag(posValid), .irq);
	home_far_side far (.clk_sys, .resetn, .cmdVelocity, .posLoad, .posLoadValue, .sensorAt,
		.feedbackPos, .reference_sensor_input(sensorIn), .encoderMarker(marker));
	always #4 clk_sys = ~clk_sys;
	// travel span and flags seen while moving backwards
	always @(negedge clk_sys) begin
		if (running === 1'b1) begin
			lo = ($signed(feedbackPos) < lo) ? $signed(feedbackPos) : lo;
			hi = ($signed(feedbackPos) > hi) ? $signed(feedbackPos) : hi;
			if ($signed(cmdVelocity) < 0) back = back | {atVel, dec, acc};
		end
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			stop_test();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge clk_sys);
		regWrStb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge clk_sys);
		regRdStb <= 1'b0;
		#1 rdVal = regRdData;
	endtask
	task automatic runHome();
		int n;
		n = 0;
		lo = $signed(feedbackPos);
		hi = lo;
		back = 3'h0;
		repeat (4) @(posedge clk_sys);
		homeTrigger <= 1'b1;
		do begin
			@(negedge clk_sys);
			n++;
		end while (running !== 1'b1 && n < 20);
		chk(32'(running), 32'h1);
		n = 0;
		while (running !== 1'b0 && n < 3000) begin
			@(negedge clk_sys);
			n++;
		end
		repeat (10) @(negedge clk_sys);
		// trigger still high here, so a restart would show
		chk(32'(running), 32'h0);
		@(posedge clk_sys);
		homeTrigger <= 1'b0;
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		seedDummy = $urandom(32'h0517_e8c5);
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
		resetn = 1'b1;
		for (int a = 0; a <= 'h30; a += 4) begin
			rd(8'(a));
			chk(rdVal, 32'h0000_0000);
		end
		endPos = $urandom_range(64, 0);
		vel = $urandom_range(8, 3);
		wr(`HOME_REG_ACCEL, 32'h0000_0002);
		wr(`HOME_REG_DECEL, 32'h0000_0001);
		wr(`HOME_REG_END_POS, endPos);
		wr(`HOME_REG_FILTER, 32'h0000_0005);
		wr(`HOME_REG_IRQ_ENABLE, 32'h0000_000F);
		wr(`HOME_REG_VELOCITY, 32'(vel));
		// sensor, marker, sensor then marker, filtered sensor
		for (int s = 0; s < 4; s++) begin
			wr(`HOME_REG_CTRL, (s == 3) ? 32'h0000_0008 : 32'(s));
			runHome();
			chk(feedbackPos, endPos);
			rd(`HOME_REG_FLAGS);
			chk(rdVal, DoneFl);
			rd(`HOME_REG_IRQ_STATUS);
			chk(rdVal, 32'h0000_0009);
			chk(32'(irq), 32'h1);
			wr(`HOME_REG_IRQ_CLEAR, 32'h0000_000F);
			@(negedge clk_sys);
			chk(32'(irq), 32'h0);
			rd(`HOME_REG_REF_POS);
			if (s == 0) begin
				// synchroniser lag puts the reference up to two steps past the pin edge
				chk(32'(rdVal >= sensorAt && rdVal < sensorAt + 3 * vel), 32'h1);
				// run-on at speed plus the full ramp, two cycles of latency allowed
				chk(32'(hi - rdVal - RunOn * vel - vel * (vel + 1) / 2 <= 2 * vel), 32'h1);
			end
			if (s == 1) chk(32'(rdVal[5:0] < 3 * vel), 32'h1);
			// a position taken at acceptance would lie five steps further on
			if (s == 3) chk(32'(rdVal >= sensorAt && rdVal < sensorAt + 3 * vel), 32'h1);
		end
		for (int b = 0; b < 6; b++) begin
			@(posedge clk_sys);
			block <= 6'h01 << b;
			repeat (4) @(posedge clk_sys);
			homeTrigger <= 1'b1;
			repeat (10) @(negedge clk_sys);
			chk({30'h0, running, done}, 32'h0000_0001);
			@(posedge clk_sys);
			homeTrigger <= 1'b0;
			block <= 6'h00;
		end
		sensorAt = 32'h7000_0000;
		wr(`HOME_REG_LIMIT_DIST, 32'h0000_0064);
		wr(`HOME_REG_CTRL, 32'h0000_0010);
		runHome();
		chk(32'(hi - $signed(endPos) <= 100 && hi - $signed(endPos) >= 84), 32'h1);
		rd(`HOME_REG_FLAGS);
		chk(rdVal, 32'h0000_0070);
		wr(`HOME_REG_CTRL, 32'h0000_0000);
		@(posedge clk_sys);
		homeTrigger <= 1'b1;
		repeat (40) @(posedge clk_sys);
		block <= 6'h08;
		repeat (8) @(negedge clk_sys);
		chk({28'h0, running, done, anyDone, limitHit}, 32'h0000_0000);
		rd(`HOME_REG_IRQ_STATUS);
		chk(rdVal & 32'h0000_0004, 32'h0000_0004);
		block <= 6'h00;
		homeTrigger <= 1'b0;
		// the aborted search may already stand past the old sensor spot
		sensorAt = feedbackPos + 32'h0000_0100;
		runHome();
		for (int p = 0; p < 2; p++) begin
			@(posedge clk_sys);
			// backup present first, so only the second pass may clear the flag
			backup_logic_supply <= !p[0];
			mainPowerLost <= 1'b1;
			repeat (6) @(negedge clk_sys);
			chk(32'(posValid), 32'(p == 0));
		end
		mainPowerLost <= 1'b0;
		backup_logic_supply <= 1'b1;
		runHome();
		encoderFault <= 1'b1;
		repeat (6) @(negedge clk_sys);
		chk(32'(posValid), 32'h0);
		encoderFault <= 1'b0;
		// sensor already made at start, back off first
		sensorAt = 32'h0000_0000;
		wr(`HOME_REG_CTRL, 32'h0000_0004);
		runHome();
		chk(32'(lo < 0), 32'h1);
		chk(32'(back), 32'h0000_0003);
		chk(32'(posValid), 32'h1);
		stop_test();
	end
endmodule
`default_nettype wire
